// File: core/pdmr_regs.svh
// Register offsets, field positions and reset values of the DMA channel pair
`ifndef PDMR_REGS_SVH
`define PDMR_REGS_SVH
// ==========================================================================
// Register byte offsets
`define PDMR_RX_CUR_PTR 8'h00
`define PDMR_RX_CUR_CNT 8'h04
`define PDMR_TX_CUR_PTR 8'h08
`define PDMR_TX_CUR_CNT 8'h0C
`define PDMR_RX_NXT_PTR 8'h10
`define PDMR_RX_NXT_CNT 8'h14
`define PDMR_TX_NXT_PTR 8'h18
`define PDMR_TX_NXT_CNT 8'h1C
`define PDMR_CTRL 8'h20
`define PDMR_STATUS 8'h24
`define PDMR_FLAGS 8'h28
`define PDMR_CONFIG 8'h2C
// ==========================================================================
// Field positions
`define PDMR_CTL_RX_EN 0
`define PDMR_CTL_RX_DIS 1
`define PDMR_CTL_TX_EN 8
`define PDMR_CTL_TX_DIS 9
`define PDMR_STS_RX 0
`define PDMR_STS_TX 8
`define PDMR_FLG_RX_END 0
`define PDMR_FLG_RX_FULL 1
`define PDMR_FLG_TX_END 2
`define PDMR_FLG_TX_EMPTY 3
`define PDMR_CFG_HD 0
`define PDMR_CFG_SIZE 1
// ==========================================================================
// Reset values and item size codes
`define PDMR_PTR_RST 32'h0000_0000
`define PDMR_CNT_RST 16'h0000
`define PDMR_SIZE_BYTE 2'h0
`define PDMR_SIZE_HALF 2'h1
`define PDMR_SIZE_WORD 2'h2
`define PDMR_STEP_BYTE 32'h0000_0001
`define PDMR_STEP_HALF 32'h0000_0002
`define PDMR_STEP_WORD 32'h0000_0004
`endif

// File: core/pdmr_pkg.sv
// Types shared by the DMA channel pair and its bench
package pdmr_pkg;
   typedef enum logic [1:0] {st_idle, st_rx_wr, st_tx_rd, st_settle} pdmr_state_t;
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] size;
   } pdmr_mem_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } pdmr_mem_rsp_t;
endpackage

// File: core/pdmr_channel.sv
// Peripheral DMA channel pair with APB register file and memory engine
// ==========================================================================
// Summary of operation
// - Transmit count zero halts transmit; non-zero runs when the channel is enabled.
// - Half-duplex uses one current count for both directions.
// - Receive next pointer holds the following buffer; shared in half-duplex.
// - Receive next count is 16 bits at 15:0; shared in half-duplex.
// - Transmit next pointer is a full 32-bit read/write address.
// - Transmit next count is 16 bits at 15:0, upper bits read zero.
// - Control bit 0 enables receive unless bit 1 is also set.
// - Control bit 1 disables receive and wins over enable.
// - Control bit 8 enables transmit requests.
// - Control bit 9 disables transmit requests.
// - Half-duplex: enabling receive turns transmit off.
// - Half-duplex: transmit enable acts only without receive enable or disable in that write.
// - Half-duplex: disabling receive turns transmit off too.
// - Half-duplex: disabling transmit turns receive off too.
// - Status bit 0 shows receive enable, bit 8 transmit enable.
// - At count zero stop and flag, or reload next pair and clear it.
// - Pointer steps 1, 2 or 4 bytes per item by size.
// - Non-zero write to current or next count clears that direction's flags.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pdmr_regs.svh"
module pdmr_channel #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk_i, // 250 MHz clock
   input wire logic rstn_i, // Synchronous reset, active low
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [7:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error on unmapped address
   input wire logic rx_ready_i, // Peripheral holds received data
   input wire logic [31:0] rx_data_i, // Received data
   output logic rx_take_o, // Pulse: received data taken
   input wire logic tx_ready_i, // Peripheral can accept data
   output logic [31:0] tx_data_o, // Data for the peripheral
   output logic tx_load_o, // Pulse: tx_data_o valid
   output pdmr_pkg::pdmr_mem_req_t mem_o, // Memory request
   input wire pdmr_pkg::pdmr_mem_rsp_t mem_i // Memory answer
);
   // =======================================================================
   // Register state
   logic [31:0] cur_ptr [2];
   logic [CNT_W-1:0] cur_cnt [2];
   logic [31:0] nxt_ptr [2];
   logic [CNT_W-1:0] nxt_cnt [2];
   logic [1:0] end_flag;
   logic [1:0] buf_flag;
   logic rx_en;
   logic tx_en;
   logic half_duplex;
   logic [1:0] item_size;
   pdmr_pkg::pdmr_state_t state;
   logic act_ch;

   // =======================================================================
   // APB decode
   wire setup = psel_i & ~penable_i;
   wire access = psel_i & penable_i & pready_o;
   wire wr_acc = access & pwrite_i;
   wire hit_rcp = paddr_i == `PDMR_RX_CUR_PTR;
   wire hit_rcc = paddr_i == `PDMR_RX_CUR_CNT;
   wire hit_tcp = paddr_i == `PDMR_TX_CUR_PTR;
   wire hit_tcc = paddr_i == `PDMR_TX_CUR_CNT;
   wire hit_rnp = paddr_i == `PDMR_RX_NXT_PTR;
   wire hit_rnc = paddr_i == `PDMR_RX_NXT_CNT;
   wire hit_tnp = paddr_i == `PDMR_TX_NXT_PTR;
   wire hit_tnc = paddr_i == `PDMR_TX_NXT_CNT;
   wire hit_ctl = paddr_i == `PDMR_CTRL;
   wire hit_sts = paddr_i == `PDMR_STATUS;
   wire hit_flg = paddr_i == `PDMR_FLAGS;
   wire hit_cfg = paddr_i == `PDMR_CONFIG;
   wire mapped = hit_rcp | hit_rcc | hit_tcp | hit_tcc | hit_rnp | hit_rnc |
                 hit_tnp | hit_tnc | hit_ctl | hit_sts | hit_flg | hit_cfg;
   wire [31:0] cnt_word = {16'h0000, pwdata_i[15:0]};
   wire [31:0] sts_word = {23'h0, tx_en, 7'h00, rx_en};
   wire [31:0] flg_word = {28'h0, buf_flag[1], end_flag[1], buf_flag[0], end_flag[0]};
   wire [31:0] cfg_word = {29'h0, item_size, half_duplex};
   wire [31:0] rd_mux =
      hit_rcp ? cur_ptr[0] :
      hit_rcc ? 32'(cur_cnt[0]) :
      hit_tcp ? cur_ptr[1] :
      hit_tcc ? 32'(cur_cnt[1]) :
      hit_rnp ? nxt_ptr[0] :
      hit_rnc ? 32'(nxt_cnt[0]) :
      hit_tnp ? nxt_ptr[1] :
      hit_tnc ? 32'(nxt_cnt[1]) :
      hit_sts ? sts_word :
      hit_flg ? flg_word :
      hit_cfg ? cfg_word : 32'h0000_0000;

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= setup;
         pslverr_o <= setup & ~mapped;
         prdata_o <= (setup & ~pwrite_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // =======================================================================
   // Request enables
   wire ctl_wr = wr_acc & hit_ctl;
   wire w_rxen = pwdata_i[`PDMR_CTL_RX_EN];
   wire w_rxdis = pwdata_i[`PDMR_CTL_RX_DIS];
   wire w_txen = pwdata_i[`PDMR_CTL_TX_EN];
   wire w_txdis = pwdata_i[`PDMR_CTL_TX_DIS];
   wire rx_off = w_rxdis | (half_duplex & w_txdis);
   wire tx_off = w_txdis | (half_duplex & (w_rxen | w_rxdis));
   wire next_rx_en = ctl_wr ? (rx_off ? 1'b0 : (w_rxen | rx_en)) : rx_en;
   wire next_tx_en = ctl_wr ? (tx_off ? 1'b0 : (w_txen | tx_en)) : tx_en;

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         rx_en <= 1'b0;
         tx_en <= 1'b0;
         half_duplex <= 1'b0;
         item_size <= `PDMR_SIZE_BYTE;
      end else begin
         rx_en <= next_rx_en;
         tx_en <= next_tx_en;
         if (wr_acc & hit_cfg) begin
            half_duplex <= pwdata_i[`PDMR_CFG_HD];
            item_size <= pwdata_i[`PDMR_CFG_SIZE +: 2];
         end
      end
   end

   // =======================================================================
   // Pointer step and engine start
   wire [31:0] step = (item_size == `PDMR_SIZE_WORD) ? `PDMR_STEP_WORD :
                      (item_size == `PDMR_SIZE_HALF) ? `PDMR_STEP_HALF :
                      `PDMR_STEP_BYTE;
   wire rx_go = rx_en & (cur_cnt[0] != '0) & rx_ready_i;
   wire tx_go = tx_en & (cur_cnt[1] != '0) & tx_ready_i;
   wire busy = (state == pdmr_pkg::st_rx_wr) | (state == pdmr_pkg::st_tx_rd);
   wire item_done = busy & mem_i.ack;

   // =======================================================================
   // Per-direction pointers, counts and flags (0 receive, 1 transmit)
   for (genvar k = 0; k < 2; k++) begin : g_dir
      wire own_cp = (k == 0) ? hit_rcp : hit_tcp;
      wire own_cc = (k == 0) ? hit_rcc : hit_tcc;
      wire own_np = (k == 0) ? hit_rnp : hit_tnp;
      wire own_nc = (k == 0) ? hit_rnc : hit_tnc;
      wire oth_cp = (k == 0) ? hit_tcp : hit_rcp;
      wire oth_cc = (k == 0) ? hit_tcc : hit_rcc;
      wire oth_np = (k == 0) ? hit_tnp : hit_rnp;
      wire oth_nc = (k == 0) ? hit_tnc : hit_rnc;
      // Half-duplex writes land in both copies so they stay one value
      wire w_cp = wr_acc & (own_cp | (half_duplex & oth_cp));
      wire w_cc = wr_acc & (own_cc | (half_duplex & oth_cc));
      wire w_np = wr_acc & (own_np | (half_duplex & oth_np));
      wire w_nc = wr_acc & (own_nc | (half_duplex & oth_nc));
      wire upd = item_done & ((act_ch == 1'(k)) | half_duplex);
      wire last = cur_cnt[k] == CNT_W'(1);
      wire reload = last & (nxt_cnt[k] != '0);
      wire clr = (w_cc | w_nc) & (pwdata_i[15:0] != 16'h0000);
      always_ff @(posedge core_clk_i) begin
         if (!rstn_i) begin
            cur_ptr[k] <= `PDMR_PTR_RST;
            cur_cnt[k] <= CNT_W'(`PDMR_CNT_RST);
            nxt_ptr[k] <= `PDMR_PTR_RST;
            nxt_cnt[k] <= CNT_W'(`PDMR_CNT_RST);
            end_flag[k] <= 1'b0;
            buf_flag[k] <= 1'b0;
         end else begin
            if (w_cp) begin
               cur_ptr[k] <= pwdata_i;
            end else if (upd) begin
               cur_ptr[k] <= reload ? nxt_ptr[k] : cur_ptr[k] + step;
            end
            if (w_cc) begin
               cur_cnt[k] <= CNT_W'(cnt_word);
            end else if (upd) begin
               cur_cnt[k] <= reload ? nxt_cnt[k] : cur_cnt[k] - CNT_W'(1);
            end
            if (w_np) begin
               nxt_ptr[k] <= pwdata_i;
            end else if (upd & reload) begin
               nxt_ptr[k] <= `PDMR_PTR_RST;
            end
            if (w_nc) begin
               nxt_cnt[k] <= CNT_W'(cnt_word);
            end else if (upd & reload) begin
               nxt_cnt[k] <= CNT_W'(`PDMR_CNT_RST);
            end
            // A completion in the same cycle as a clearing write wins
            end_flag[k] <= (upd & last) | (end_flag[k] & ~clr);
            buf_flag[k] <= (upd & last & ~reload) | (buf_flag[k] & ~clr);
         end
      end
   end

   // =======================================================================
   // Memory engine
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         state <= pdmr_pkg::st_idle;
         act_ch <= 1'b0;
         mem_o <= '0;
         rx_take_o <= 1'b0;
         tx_load_o <= 1'b0;
         tx_data_o <= 32'h0000_0000;
      end else begin
         rx_take_o <= 1'b0;
         tx_load_o <= 1'b0;
         case (state)
            pdmr_pkg::st_idle: begin
               if (rx_go) begin
                  state <= pdmr_pkg::st_rx_wr;
                  act_ch <= 1'b0;
                  rx_take_o <= 1'b1;
                  mem_o <= '{req: 1'b1, we: 1'b1, addr: cur_ptr[0],
                             wdata: rx_data_i, size: item_size};
               end else if (tx_go) begin
                  state <= pdmr_pkg::st_tx_rd;
                  act_ch <= 1'b1;
                  mem_o <= '{req: 1'b1, we: 1'b0, addr: cur_ptr[1],
                             wdata: 32'h0000_0000, size: item_size};
               end
            end
            pdmr_pkg::st_rx_wr, pdmr_pkg::st_tx_rd: begin
               if (mem_i.ack) begin
                  mem_o.req <= 1'b0;
                  mem_o.we <= 1'b0;
                  state <= pdmr_pkg::st_settle;
                  if (state == pdmr_pkg::st_tx_rd) begin
                     tx_data_o <= mem_i.rdata;
                     tx_load_o <= 1'b1;
                  end
               end
            end
            // One idle cycle lets the peripheral drop its ready
            pdmr_pkg::st_settle: begin
               state <= pdmr_pkg::st_idle;
            end
            default: begin
               state <= pdmr_pkg::st_idle;
            end
         endcase
      end
   end

   // =======================================================================
   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_ctl_write;
      ctl_wr;
   endsequence
   sequence s_item_end(ch);
      item_done && act_ch == ch && !half_duplex && !wr_acc;
   endsequence
   sequence s_mem_answer;
      mem_o.req ##[1:300] mem_i.ack;
   endsequence
   sequence s_hd_write(hit_a, hit_b);
      wr_acc && half_duplex && (hit_a || hit_b);
   endsequence

   chk_zero_count_halts: assert property (
      (state == pdmr_pkg::st_idle) && cur_cnt[1] == '0 && !rx_go
      |=> state != pdmr_pkg::st_tx_rd)
      else $error("transmit started with zero count");
   chk_hd_count_shared: assert property (
      wr_acc && half_duplex && (hit_rcc || hit_tcc) |=> cur_cnt[0] == cur_cnt[1])
      else $error("half-duplex counts differ after write");
   chk_next_ptr_store: assert property (
      wr_acc && hit_tnp |=> nxt_ptr[1] == $past(pwdata_i))
      else $error("transmit next pointer not stored");
   chk_next_cnt_width: assert property (
      access && !pwrite_i && (hit_rnc || hit_tnc) |-> prdata_o[31:16] == 16'h0000)
      else $error("next count upper bits not zero");
   chk_rx_enable: assert property (
      s_ctl_write ##0 (w_rxen && !w_rxdis && !(half_duplex && w_txdis)) |=> rx_en)
      else $error("receive enable not taken");
   chk_rx_disable_wins: assert property (
      s_ctl_write ##0 w_rxdis |=> !rx_en)
      else $error("receive disable did not win");
   chk_tx_enable: assert property (
      s_ctl_write ##0 (w_txen && !w_txdis && !half_duplex) |=> tx_en)
      else $error("transmit enable not taken");
   chk_tx_disable: assert property (
      s_ctl_write ##0 w_txdis |=> !tx_en)
      else $error("transmit disable not taken");
   chk_hd_rx_stops_tx: assert property (
      s_ctl_write ##0 (half_duplex && (w_rxen || w_rxdis)) |=> !tx_en)
      else $error("half-duplex transmit still enabled");
   chk_hd_tx_stops_rx: assert property (
      s_ctl_write ##0 (half_duplex && w_txdis) |=> !rx_en)
      else $error("half-duplex receive still enabled");
   chk_status_bits: assert property (
      access && !pwrite_i && hit_sts
      |-> prdata_o[0] == rx_en && prdata_o[8] == tx_en)
      else $error("status does not match enables");
   chk_reload_next: assert property (
      s_item_end(1'b1) ##0 (cur_cnt[1] == CNT_W'(1) && nxt_cnt[1] != '0)
      |=> nxt_cnt[1] == '0 && cur_cnt[1] == $past(nxt_cnt[1]) && end_flag[1])
      else $error("next pair not reloaded");
   chk_pointer_step: assert property (
      s_item_end(1'b0) ##0 (cur_cnt[0] != CNT_W'(1))
      |=> cur_ptr[0] == $past(cur_ptr[0]) + $past(step))
      else $error("receive pointer step wrong");
   chk_take_then_write: assert property (
      rx_take_o |-> mem_o.we ##0 s_mem_answer)
      else $error("received item not written to memory");

   // =======================================================================
   // Shared copies, flags and engine steps
   chk_hd_ptr_shared: assert property (
      s_hd_write(hit_rcp, hit_tcp)
      |=> cur_ptr[0] == cur_ptr[1])
      else $error("half-duplex pointers differ after write");

   chk_hd_next_shared: assert property (
      s_hd_write(hit_rnp, hit_tnp)
      |=> nxt_ptr[0] == nxt_ptr[1])
      else $error("half-duplex next pointers differ after write");

   chk_hd_next_count: assert property (
      s_hd_write(hit_rnc, hit_tnc)
      |=> nxt_cnt[0] == nxt_cnt[1])
      else $error("half-duplex next counts differ after write");

   chk_hd_tx_enable: assert property (
      s_ctl_write ##0 (half_duplex && w_txen && !w_rxen && !w_rxdis && !w_txdis)
      |=> tx_en)
      else $error("half-duplex transmit enable not taken");

   chk_hd_rx_off: assert property (
      s_ctl_write ##0 (half_duplex && w_rxdis)
      |=> !rx_en && !tx_en)
      else $error("half-duplex receive disable left a channel on");

   chk_flag_clear: assert property (
      wr_acc && hit_rcc && pwdata_i[15:0] != 16'h0000 && !item_done
      |=> !end_flag[0] && !buf_flag[0])
      else $error("receive flags not cleared by count write");

   chk_stop_flags: assert property (
      s_item_end(1'b0) ##0 (cur_cnt[0] == CNT_W'(1) && nxt_cnt[0] == '0)
      |=> cur_cnt[0] == '0 && end_flag[0] && buf_flag[0])
      else $error("receive channel did not stop and flag");

   chk_count_step: assert property (
      s_item_end(1'b0) ##0 (cur_cnt[0] != CNT_W'(1))
      |=> cur_cnt[0] == $past(cur_cnt[0]) - CNT_W'(1))
      else $error("receive count not decremented");

   chk_no_take_idle: assert property (
      (!rx_en || cur_cnt[0] == '0)
      |=> !rx_take_o)
      else $error("item taken while receive is off or empty");

   chk_tx_step: assert property (
      s_item_end(1'b1) ##0 (cur_cnt[1] != CNT_W'(1))
      |=> cur_ptr[1] == $past(cur_ptr[1]) + $past(step))
      else $error("transmit pointer step wrong");

   chk_tx_load_data: assert property (
      state == pdmr_pkg::st_tx_rd && mem_i.ack
      |=> tx_load_o && tx_data_o == $past(mem_i.rdata))
      else $error("transmit item not handed to peripheral");
endmodule
`default_nettype wire

// File: core/unused_placeholder_none.sv
// Intentionally empty compile unit marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: bench/pdmr_partner.sv
// Serial peripheral and memory matrix model facing the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
module pdmr_partner (
   input wire logic clk_i, // Bench clock
   input wire logic rx_go_i, // Offer received items
   input wire logic tx_go_i, // Accept transmit items
   input wire logic [1:0] dly_i, // Memory answer delay
   input wire logic rx_take_i, // Item taken
   input wire logic tx_load_i, // Item loaded
   input wire pdmr_pkg::pdmr_mem_req_t mem_i, // Memory request
   output logic rx_ready_o, // Item held
   output logic [31:0] rx_data_o, // Held item
   output logic tx_ready_o, // Room for an item
   output pdmr_pkg::pdmr_mem_rsp_t mem_o // Memory answer
);
   logic [1:0] wait_cnt = 2'h0;
   logic [31:0] item = 32'hC0DE_0000;
   // No item held: data line shows the inverse
   assign rx_data_o = rx_ready_o ? item : ~item;
   initial begin
      rx_ready_o = 1'b0;
      tx_ready_o = 1'b0;
      mem_o = '0;
   end
   always @(posedge clk_i) begin
      rx_ready_o <= rx_go_i && !rx_take_i;
      tx_ready_o <= tx_go_i && !tx_load_i;
      if (rx_take_i) begin
         item <= item + 32'h1;
      end
      mem_o.ack <= 1'b0;
      mem_o.rdata <= ~mem_o.rdata;
      if (mem_i.req && !mem_o.ack) begin
         if (wait_cnt == dly_i) begin
            mem_o.ack <= 1'b1;
            mem_o.rdata <= mem_i.addr ^ 32'h5A5A_0F0F;
            wait_cnt <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/test_peripheral_dma_channel_regs.sv
// Self-checking bench for the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_dma_channel_regs;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, tx_data, rx_data, rd, ea;
   logic prdy, perr, rx_ready, rx_take, tx_ready, tx_load, er, req_q = 1'b0;
   logic rx_go = 1'b0, tx_go = 1'b0, hd = 1'b0, rx_m = 1'b0, tx_m = 1'b0, exp_we = 1'b0;
   logic [1:0] dly = 2'h0, cur_sz = 2'h0;
   pdmr_pkg::pdmr_mem_req_t mem_req;
   pdmr_pkg::pdmr_mem_rsp_t mem_rsp;
   int n_fail = 0, n_tests = 0, rx_idx = 0, n_take = 0;
   integer seed = 32'h59C4;
   logic [31:0] exp_addr[$], exp_tx[$];
   initial begin
      forever #2 clk = ~clk;
   end
   pdmr_channel dut_u (.core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .rx_ready_i(rx_ready), .rx_data_i(rx_data), .rx_take_o(rx_take),
      .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_load_o(tx_load), .mem_o(mem_req),
      .mem_i(mem_rsp));
   pdmr_partner far_u (.clk_i(clk), .rx_go_i(rx_go), .tx_go_i(tx_go), .dly_i(dly),
      .rx_take_i(rx_take), .tx_load_i(tx_load), .mem_i(mem_req), .rx_ready_o(rx_ready),
      .rx_data_o(rx_data), .tx_ready_o(tx_ready), .mem_o(mem_rsp));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // APB master: setup, then access until ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg_%h", a), rd, exp);
   endtask
   task wait_flag(input logic [31:0] m);
      do begin
         apb(1'b0, 8'h28, 32'h0);
      end while ((rd & m) !== m);
   endtask
   // Behavioural model of the control write
   task ctl(input logic [31:0] w);
      wr(8'h20, w);
      if (w[0] && !w[1]) begin
         rx_m = 1'b1;
         if (hd) tx_m = 1'b0;
      end
      if (w[1]) begin
         rx_m = 1'b0;
         if (hd) tx_m = 1'b0;
      end
      if (w[8] && !(hd && w[0])) tx_m = 1'b1;
      if (w[9]) begin
         tx_m = 1'b0;
         if (hd) rx_m = 1'b0;
      end
      rdc(8'h24, {23'h0, tx_m, 7'h0, rx_m});
   endtask
   task rx_run(input logic [1:0] sz, input logic [31:0] p, input int n, input int nn);
      logic [31:0] st;
      st = 32'h1 << sz;
      cur_sz = sz;
      exp_we = 1'b1;
      dly <= 2'($random(seed));
      wr(8'h2C, {29'h0, sz, 1'b0});
      wr(8'h00, p);
      wr(8'h04, n);
      wr(8'h10, p + 32'h100);
      wr(8'h14, nn);
      for (int i = 0; i < n; i++) exp_addr.push_back(p + i * st);
      for (int i = 0; i < nn; i++) exp_addr.push_back(p + 32'h100 + i * st);
      wr(8'h20, 32'h1);
      rx_go <= 1'b1;
      wait_flag(32'h2);
      rdc(8'h04, 32'h0);
      rdc(8'h14, 32'h0);
      rdc(8'h10, nn > 0 ? 32'h0 : p + 32'h100);
      rdc(8'h00, nn > 0 ? p + 32'h100 + nn * st : p + n * st);
      rdc(8'h28, 32'h3);
      chk("rx_left", exp_addr.size(), 32'h0);
      wr(8'h20, 32'h2);
      wr(8'h04, 32'h5);
      repeat (10) @(posedge clk);
      rdc(8'h28, 32'h0);
      wr(8'h04, 32'h0);
      rx_go <= 1'b0;
   endtask
   // Monitor: every memory request against the model
   always @(posedge clk) begin
      req_q <= mem_req.req;
      if (rstn && mem_req.req && !req_q) begin
         ea = exp_addr.size() > 0 ? exp_addr.pop_front() : 32'hDEAD_0001;
         chk("mem_addr", mem_req.addr, ea);
         chk("mem_size", {30'h0, mem_req.size}, {30'h0, cur_sz});
         chk("mem_dir", {31'h0, mem_req.we}, {31'h0, exp_we});
         if (exp_we && cur_sz == 2'h2) begin
            chk("mem_wdata", mem_req.wdata, 32'hC0DE_0000 + rx_idx);
         end
         if (exp_we) rx_idx++;
      end
      if (rstn && rx_take) n_take++;
      if (tx_load) begin
         chk("tx_data", tx_data, exp_tx.size() > 0 ? exp_tx.pop_front() : 32'h0);
      end
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      $display("watchdog expired");
      summarize();
   end
   initial begin
      logic [7:0] ta[4];
      logic [31:0] d, p;
      logic [31:0] fd[5], hdt[7];
      ta = '{8'h10, 8'h14, 8'h18, 8'h1C};
      fd = '{32'h001, 32'h003, 32'h101, 32'h002, 32'h200};
      hdt = '{32'h100, 32'h001, 32'h100, 32'h002, 32'h100, 32'h001, 32'h200};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a <= 8'h28; a += 4) rdc(a[7:0], 32'h0);
      apb(1'b1, 8'h30, 32'h1);
      chk("unmapped_err", {31'h0, er}, 32'h1);
      wr(8'h24, 32'hFFFF_FFFF);
      rdc(8'h24, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(ta[i], d);
         rdc(ta[i], ta[i][2] ? d & 32'hFFFF : d);
         wr(ta[i], 32'h0);
      end
      $display("test registers done");
      foreach (fd[i]) ctl(fd[i]);
      hd = 1'b1;
      wr(8'h2C, 32'h1);
      foreach (hdt[i]) ctl(hdt[i]);
      $display("test control done");
      d = $random(seed);
      wr(8'h08, d);
      rdc(8'h00, d);
      wr(8'h0C, 32'h7);
      rdc(8'h04, 32'h7);
      wr(8'h18, ~d);
      rdc(8'h10, ~d);
      wr(8'h14, 32'h9);
      rdc(8'h1C, 32'h9);
      wr(8'h04, 32'h0);
      wr(8'h14, 32'h0);
      hd = 1'b0;
      $display("test half duplex done");
      for (int s = 0; s < 3; s++) begin
         p = $random(seed) & 32'h0FFF_FFF0;
         rx_run(s[1:0], p, 3, s == 2 ? 2 : 0);
      end
      chk("rx_takes", n_take, 32'hB);
      $display("test receive done");
      cur_sz = 2'h1;
      exp_we = 1'b0;
      wr(8'h2C, 32'h2);
      wr(8'h08, 32'h3000);
      wr(8'h0C, 32'h2);
      wr(8'h18, 32'h4000);
      wr(8'h1C, 32'h1);
      for (int i = 0; i < 3; i++) begin
         exp_addr.push_back(i < 2 ? 32'h3000 + 2 * i : 32'h4000);
         exp_tx.push_back((i < 2 ? 32'h3000 + 2 * i : 32'h4000) ^ 32'h5A5A_0F0F);
      end
      wr(8'h20, 32'h100);
      tx_go <= 1'b1;
      wait_flag(32'h8);
      rdc(8'h08, 32'h4002);
      rdc(8'h1C, 32'h0);
      rdc(8'h18, 32'h0);
      rdc(8'h28, 32'hC);
      repeat (20) @(posedge clk);
      chk("tx_halt", {31'h0, mem_req.req}, 32'h0);
      wr(8'h20, 32'h200);
      tx_go <= 1'b0;
      $display("test transmit done");
      summarize();
   end
endmodule
`default_nettype wire
